// File: verilog/svd_defs.svh
`ifndef SVD_DEFS_SVH
`define SVD_DEFS_SVH
// Register indices; the byte address is four times the index.
`define SVD_IDX_SSC 8'h02
`define SVD_IDX_ERRA 8'h1A
`define SVD_IDX_ERRB 8'h1B
`define SVD_IDX_CTRL 8'h20
`define SVD_IDX_GPIO 8'h21
`define SVD_IDX_STAT 8'h22
// Control register bit positions.
`define SVD_CTRL_SEL 0
`define SVD_CTRL_SRC 1
`define SVD_CTRL_BCEN 2
`define SVD_CTRL_EDGE 3
`define SVD_CTRL_XOSC 4
// Reset values.
`define SVD_CTRL_RST 8'h08
`define SVD_GPIO_RST 8'h00
`define SVD_SSC_RST 8'h00
// Forward frame layout: parity, two syncs, payload valid, payload.
`define SVD_FRAME_BITS 28
`define SVD_PAR_BIT 27
`define SVD_VAL_BIT 24
`define SVD_BACK_BITS 8
// Timing figures.
`define SVD_CLK_MHZ 100
`define SVD_LINK_DIV 8
`define SVD_LINE_MAX_MBPS 1400
`define SVD_LINE_MBPS (`SVD_CLK_MHZ / `SVD_LINK_DIV)
`define SVD_LOCK_FRAMES 4
`define SVD_LINK_TIMEOUT 64
`define SVD_GPIO_SKEW_US 25
`define SVD_GPIO_SKEW_CYC (`SVD_GPIO_SKEW_US * `SVD_CLK_MHZ)
`define SVD_SEQ_CLK 5
`define SVD_SEQ_END 6
`define SVD_POOL_BITS 48
`endif

// File: verilog/svd_pkg.sv
package svd_pkg;
   // Data width modes of the link.
   typedef enum logic [1:0] {SVD_MODE_12LF, SVD_MODE_12HF, SVD_MODE_10B} svd_mode_t;
   // Receiver lock states.
   typedef enum logic [1:0] {SVD_ST_OFF, SVD_ST_SEEK, SVD_ST_LOCK} svd_lock_t;

   // Bits in one pixel for a mode.
   function automatic logic [5:0] svd_pix_bits(svd_mode_t m);
      return (m == SVD_MODE_10B) ? 6'd10 : 6'd12;
   endfunction

   // Payload bits carried by one frame: one, one and a half or two pixels.
   function automatic logic [5:0] svd_pay_bits(svd_mode_t m);
      case (m)
         SVD_MODE_12LF: return 6'd12;
         SVD_MODE_12HF: return 6'd18;
         default: return 6'd20;
      endcase
   endfunction

   // Four-bit check code, polynomial x^4+x+1, data taken high bit first.
   function automatic logic [3:0] svd_crc4(logic [3:0] d);
      logic [3:0] c;
      logic fb;
      c = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         fb = c[3] ^ d[i];
         c = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
      end
      return c;
   endfunction
endpackage

// File: verilog/svd_link_if.sv
`timescale 1ns/1ps
// One serial link between a serializer and one input of the deserializer.
interface svd_link_if;
   logic s_clk; // Link bit clock made by the serializer.
   logic s_dat; // Forward bit, changes after the falling link clock edge.
   logic s_frm; // High during bit 0 of each forward frame.
   logic b_dat; // Back-channel bit.
   logic b_oe; // Back-channel driver on.
   modport ser (output s_clk, output s_dat, output s_frm, input b_dat, input b_oe);
   modport des (input s_clk, input s_dat, input s_frm, output b_dat, output b_oe);
endinterface

// File: verilog/svd_ser_end.sv
`timescale 1ns/1ps
`include "svd_defs.svh"
module svd_ser_end (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   svd_link_if.ser lnk,
   input wire svd_pkg::svd_mode_t mode_in,
   input wire logic [11:0] pix_data_in,
   input wire logic [1:0] line_frame_syncs_in,
   input wire logic pix_valid_in,
   output logic pix_ready_out,
   input wire logic par_err_inject_in,
   output logic [3:0] gpo_out,
   output logic back_crc_err_out
);
   import svd_pkg::*;

   logic [2:0] div_r; // Link clock divider phase.
   logic clk_r, dat_r, frm_r;
   logic [4:0] bit_r; // Index of the next forward bit to send.
   logic [27:0] fr_r; // Frame being sent.
   logic [47:0] pool_r; // Pixel bits waiting for a frame.
   logic [5:0] cnt_r; // Valid bits in the pool.
   logic rdy_r;
   logic [1:0] s1_r, s2_r; // Back-channel synchroniser {oe, dat}.
   logic [7:0] bsh_r; // Collected back frame.
   logic oe_all_r; // Driver seen on through the whole back frame.
   logic [3:0] gpo_r;
   logic err_r;

   wire fall_w = (div_r == 3'd3);
   wire rise_w = (div_r == 3'd7);
   wire start_w = fall_w & (bit_r == 5'd0);
   wire [5:0] pw_w = svd_pay_bits(mode_in);
   wire [5:0] wpix_w = svd_pix_bits(mode_in);
   wire have_w = (cnt_r >= pw_w);
   wire [23:0] pay_w = have_w ? (pool_r[23:0] & ~(24'hFFFFFF << pw_w)) : 24'h0;
   wire [26:0] body_w = {line_frame_syncs_in, have_w, pay_w};
   // One even parity bit per forward frame.
   wire [27:0] fr_new_w = {(^body_w) ^ par_err_inject_in, body_w};
   wire take_w = start_w & have_w;
   wire acc_w = pix_valid_in & rdy_r;
   wire [47:0] pool_t_w = take_w ? (pool_r >> pw_w) : pool_r;
   wire [5:0] cnt_t_w = take_w ? (cnt_r - pw_w) : cnt_r;
   wire [11:0] pix_w = pix_data_in & ~(12'hFFF << wpix_w);
   wire [47:0] pool_nxt = acc_w ? (pool_t_w | (48'(pix_w) << cnt_t_w)) : pool_t_w;
   wire [5:0] cnt_nxt = acc_w ? (cnt_t_w + wpix_w) : cnt_t_w;

   assign lnk.s_clk = clk_r;
   assign lnk.s_dat = dat_r;
   assign lnk.s_frm = frm_r;
   assign pix_ready_out = rdy_r;
   assign gpo_out = gpo_r;
   assign back_crc_err_out = err_r;

   // Divider makes a bit clock of LINK_DIV cycles; a frame is 28 bits.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         div_r <= 3'd0;
         clk_r <= 1'b0;
      end else begin
         div_r <= div_r + 3'd1;
         if (rise_w) begin
            clk_r <= 1'b1;
         end else if (fall_w) begin
            clk_r <= 1'b0;
         end
      end
   end

   // Forward bits change with the falling link clock edge.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bit_r <= 5'd0;
         dat_r <= 1'b0;
         frm_r <= 1'b0;
         fr_r <= 28'h0;
      end else if (fall_w) begin
         frm_r <= start_w;
         if (start_w) begin
            fr_r <= fr_new_w;
            dat_r <= fr_new_w[0];
         end else begin
            dat_r <= fr_r[bit_r];
         end
         bit_r <= (bit_r == 5'd27) ? 5'd0 : bit_r + 5'd1;
      end
   end

   // Pixels fill the pool; a frame drains one payload when the pool holds one. Ready stalls the source.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pool_r <= 48'h0;
         cnt_r <= 6'd0;
         rdy_r <= 1'b0;
      end else begin
         pool_r <= pool_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= (cnt_nxt <= 6'd36);
      end
   end

   // Back-channel lines come from another clock domain.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         s1_r <= 2'b00;
         s2_r <= 2'b00;
      end else begin
         s1_r <= {lnk.b_oe, lnk.b_dat};
         s2_r <= s1_r;
      end
   end

   // Back bit k leaves the far end after the fall that starts forward bit k+1 and has
   // crossed the synchroniser by the fall that starts bit k+2; check after slot 7.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bsh_r <= 8'h0;
         oe_all_r <= 1'b0;
         gpo_r <= 4'h0;
         err_r <= 1'b0;
      end else begin
         err_r <= 1'b0;
         if (start_w) begin
            oe_all_r <= 1'b1;
         end else if (fall_w && bit_r >= 5'd2 && bit_r <= 5'd9) begin
            bsh_r[3'(bit_r - 5'd2)] <= s2_r[0];
            oe_all_r <= oe_all_r & s2_r[1];
         end else if (fall_w && bit_r == 5'd10 && oe_all_r) begin
            if (svd_crc4(bsh_r[3:0]) == bsh_r[7:4]) begin
               gpo_r <= bsh_r[3:0];
            end else begin
               err_r <= 1'b1;
            end
         end
      end
   end
endmodule // svd_ser_end

// File: verilog/svd_des_end.sv
`timescale 1ns/1ps
`include "svd_defs.svh"
module svd_des_end (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   svd_link_if.des lnk_a,
   svd_link_if.des lnk_b,
   input wire svd_pkg::svd_mode_t mode_in,
   input wire logic power_enable_pin_in,
   input wire logic input_select_pin_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [11:0] pix_data_out,
   output logic [1:0] line_frame_syncs_out,
   output logic pix_clk_out,
   output logic lock_out,
   output logic pass_out,
   output logic out_enable_out,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe_out
);
   import svd_pkg::*;

   logic lane_r; // Active input, 0 for A and 1 for B.
   logic [10:0] s1_r, s2_r; // Pin synchroniser stages.
   logic clk_d_r; // Delayed synchronised link clock for edge finding.
   logic [4:0] bit_r; // Next forward bit index; 28 means waiting for a frame.
   logic [27:0] sh_r; // Forward frame being collected.
   svd_lock_t st_r, st_nxt; // Lock state.
   logic [2:0] good_r; // Good frames seen while seeking.
   logic [6:0] idle_r; // Cycles since the last link clock rise.
   logic [15:0] err_r; // Parity error count.
   logic pass_r, lock_r, oe_r, pclk_r;
   logic [47:0] pool_r; // Received payload bits.
   logic [5:0] cnt_r;
   logic [1:0] syncs_r; // Syncs of the latest frame.
   logic [15:0] hold_r, out_r; // Pixel waiting and pixel on the pins.
   logic [4:0] seq_r; // Output sequencer step, 0 when idle.
   logic [7:0] lfsr_r; // Random source for staggering.
   logic [3:0] tri_r, gap_r; // Spread triangle and current extra gap.
   logic tri_up_r;
   logic [7:0] ctrl_r, gpio_r, ssc_r; // Software registers.
   logic [7:0] bfr_r; // Back frame being sent.
   logic bd_r, boea_r, boeb_r;
   logic [3:0] gout_r, goe_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;

   // The 2:1 selector: only the active input reaches the receiver.
   wire [2:0] lane_w = lane_r ? {lnk_b.s_clk, lnk_b.s_dat, lnk_b.s_frm}
                              : {lnk_a.s_clk, lnk_a.s_dat, lnk_a.s_frm};
   wire [10:0] pin_w = {power_enable_pin_in, input_select_pin_in, gpio_in, mode_in, lane_w};
   wire frm_s = s2_r[0];
   wire dat_s = s2_r[1];
   wire clk_s = s2_r[2];
   wire svd_mode_t mode_s = svd_mode_t'(s2_r[4:3]);
   wire [3:0] gpio_s = s2_r[8:5];
   wire sel_pin_s = s2_r[9];
   wire pwr_s = s2_r[10];
   wire rise_w = clk_s & ~clk_d_r;
   wire fall_w = ~clk_s & clk_d_r;
   wire sel_w = ctrl_r[`SVD_CTRL_SRC] ? ctrl_r[`SVD_CTRL_SEL] : sel_pin_s;
   wire lane_chg_w = (lane_r != sel_w);
   wire [27:0] frame_w = {dat_s, sh_r[26:0]};
   wire done_w = rise_w & ~frm_s & (bit_r == 5'd27);
   wire par_ok_w = ~^frame_w;
   wire tmo_w = (idle_r == 7'(`SVD_LINK_TIMEOUT));
   wire lock_w = (st_r == SVD_ST_LOCK);
   wire edge_w = ctrl_r[`SVD_CTRL_EDGE];
   wire [3:0] dir_w = gpio_r[3:0] | (ctrl_r[`SVD_CTRL_XOSC] ? 4'hC : 4'h0);
   wire [3:0] gin_w = gpio_s & ~dir_w;
   wire [4:0] bidx_w = bit_r - 5'd1;

   // Payload bookkeeping: one, 1.5 or 2 pixels per frame.
   wire [5:0] pw_w = svd_pay_bits(mode_s);
   wire [5:0] wpix_w = svd_pix_bits(mode_s);
   wire emit_w = lock_w & (seq_r == 5'd0) & (cnt_r >= wpix_w);
   wire app_w = lock_w & done_w & frame_w[`SVD_VAL_BIT] & (cnt_r <= 6'd28);
   wire [47:0] pool_a_w = emit_w ? (pool_r >> wpix_w) : pool_r;
   wire [5:0] cnt_a_w = emit_w ? (cnt_r - wpix_w) : cnt_r;
   wire [23:0] pay_w = frame_w[23:0] & ~(24'hFFFFFF << pw_w);
   wire [47:0] pool_nxt = app_w ? (pool_a_w | (48'(pay_w) << cnt_a_w)) : pool_a_w;
   wire [5:0] cnt_nxt = app_w ? (cnt_a_w + pw_w) : cnt_a_w;
   wire [11:0] pix_w = pool_r[11:0] & ~(12'hFFF << wpix_w);
   wire [4:0] end_w = 5'(`SVD_SEQ_END) + {1'b0, gap_r};

   // Register decode over APB; index is the word address.
   wire [7:0] idx_w = {2'b00, paddr_in[7:2]};
   wire al_w = (paddr_in[1:0] == 2'b00);
   wire h_ssc = al_w & (idx_w == `SVD_IDX_SSC);
   wire h_erra = al_w & (idx_w == `SVD_IDX_ERRA);
   wire h_errb = al_w & (idx_w == `SVD_IDX_ERRB);
   wire h_ctrl = al_w & (idx_w == `SVD_IDX_CTRL);
   wire h_gpio = al_w & (idx_w == `SVD_IDX_GPIO);
   wire h_stat = al_w & (idx_w == `SVD_IDX_STAT);
   wire hit_w = h_ssc | h_erra | h_errb | h_ctrl | h_gpio | h_stat;
   wire setup_w = psel_in & ~penable_in;
   wire wr_w = psel_in & penable_in & pwrite_in & pready_r;
   wire [7:0] stat_w = {gpio_s, 1'b0, lane_r, pass_r, lock_r};
   wire [7:0] rd_w = ({8{h_ssc}} & ssc_r) | ({8{h_erra}} & err_r[7:0])
                   | ({8{h_errb}} & err_r[15:8]) | ({8{h_ctrl}} & ctrl_r)
                   | ({8{h_gpio}} & gpio_r) | ({8{h_stat}} & stat_w);

   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign pix_data_out = out_r[11:0];
   assign line_frame_syncs_out = out_r[13:12];
   assign pix_clk_out = pclk_r;
   assign lock_out = lock_r;
   assign pass_out = pass_r;
   assign out_enable_out = oe_r;
   assign gpio_out = gout_r;
   assign gpio_oe_out = goe_r;
   assign lnk_a.b_dat = bd_r;
   assign lnk_b.b_dat = bd_r;
   assign lnk_a.b_oe = boea_r;
   assign lnk_b.b_oe = boeb_r;

   // The mode, power, select, GPIO and link pins pass two flip-flops; the edge finder reads only the second.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         s1_r <= 11'h0;
         s2_r <= 11'h0;
         clk_d_r <= 1'b0;
      end else begin
         s1_r <= pin_w;
         s2_r <= s1_r;
         clk_d_r <= clk_s;
      end
   end

   // Forward bits are taken at the rising link clock edge.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bit_r <= 5'd28;
         sh_r <= 28'h0;
      end else if (rise_w) begin
         if (frm_s) begin
            sh_r[0] <= dat_s;
            bit_r <= 5'd1;
         end else if (bit_r < 5'd28) begin
            sh_r[bit_r] <= dat_s;
            bit_r <= bit_r + 5'd1;
         end
      end
   end

   // Lock sequence: power, then several good frames in a row.
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         SVD_ST_OFF: begin
            st_nxt = SVD_ST_SEEK;
         end
         SVD_ST_SEEK: begin
            if (done_w && par_ok_w && good_r == 3'(`SVD_LOCK_FRAMES - 1)) begin
               st_nxt = SVD_ST_LOCK;
            end
         end
         SVD_ST_LOCK: begin
            if (tmo_w) begin
               st_nxt = SVD_ST_SEEK;
            end
         end
         default: begin
            st_nxt = SVD_ST_OFF;
         end
      endcase
      if (!pwr_s) begin
         st_nxt = SVD_ST_OFF;
      end else if (lane_chg_w && st_r != SVD_ST_OFF) begin
         st_nxt = SVD_ST_SEEK;
      end
   end

   // State, good frame run, link idle timer and the active input.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         st_r <= SVD_ST_OFF;
         good_r <= 3'd0;
         idle_r <= 7'd0;
         lane_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         lane_r <= sel_w;
         idle_r <= rise_w ? 7'd0 : (tmo_w ? idle_r : idle_r + 7'd1);
         if (st_r != SVD_ST_SEEK || tmo_w || lane_chg_w) begin
            good_r <= 3'd0;
         end else if (done_w) begin
            good_r <= par_ok_w ? good_r + 3'd1 : 3'd0;
         end
      end
   end

   // Error count clears out of lock and saturates; pass follows each frame.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         err_r <= 16'h0;
         pass_r <= 1'b0;
         lock_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         lock_r <= lock_w;
         oe_r <= pwr_s;
         if (!lock_w) begin
            err_r <= 16'h0;
            pass_r <= 1'b0;
         end else if (done_w) begin
            pass_r <= par_ok_w;
            if (!par_ok_w && err_r != 16'hFFFF) begin
               err_r <= err_r + 16'h1;
            end
         end
      end
   end

   // Pool of payload bits and the pixel handed to the output sequencer.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !lock_w) begin
         pool_r <= 48'h0;
         cnt_r <= 6'd0;
         syncs_r <= 2'b00;
         hold_r <= 16'h0;
      end else begin
         pool_r <= pool_nxt;
         cnt_r <= cnt_nxt;
         if (app_w) begin
            syncs_r <= frame_w[26:25];
         end
         if (emit_w) begin
            hold_r <= {2'b00, syncs_r, pix_w};
         end
      end
   end

   // Sequencer, random source and spread triangle; gap shaped by profile.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !lock_w) begin
         seq_r <= 5'd0;
         lfsr_r <= 8'h5A;
         tri_r <= 4'h0;
         tri_up_r <= 1'b1;
         gap_r <= 4'h0;
      end else if (emit_w) begin
         seq_r <= 5'd1;
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         tri_r <= tri_up_r ? tri_r + 4'h1 : tri_r - 4'h1;
         tri_up_r <= tri_up_r ? (tri_r != 4'hE) : (tri_r == 4'h1);
         gap_r <= tri_r & ssc_r[3:0];
      end else if (seq_r != 5'd0) begin
         seq_r <= (seq_r == end_w) ? 5'd0 : seq_r + 5'd1;
      end
   end

   // Each nibble group moves at its own random step inside a 4-cycle window.
   for (genvar g = 0; g < 4; g++) begin : g_stag
      always_ff @(posedge ref_clk_in) begin
         if (reset_in || !lock_w) begin
            out_r[4*g +: 4] <= 4'h0;
         end else if (seq_r == 5'd1 + {3'b000, lfsr_r[2*g +: 2]}) begin
            out_r[4*g +: 4] <= hold_r[4*g +: 4];
         end
      end
   end

   // Pixel clock makes the chosen edge after the data window.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pclk_r <= 1'b0;
      end else begin
         pclk_r <= (lock_w && seq_r == 5'(`SVD_SEQ_CLK)) ? edge_w : ~edge_w;
      end
   end

   // Back frame: forwarded input pins and their check code.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bfr_r <= 8'h0;
         bd_r <= 1'b0;
         boea_r <= 1'b0;
         boeb_r <= 1'b0;
      end else begin
         if (rise_w && frm_s) begin
            bfr_r <= {svd_crc4(gin_w), gin_w};
         end
         if (fall_w) begin
            bd_r <= (bidx_w < 5'd8) ? bfr_r[bidx_w[2:0]] : 1'b0;
         end
         // Driver only on the selected input, once software enables it.
         boea_r <= pwr_s & ctrl_r[`SVD_CTRL_BCEN] & ~sel_w;
         boeb_r <= pwr_s & ctrl_r[`SVD_CTRL_BCEN] & sel_w;
      end
   end

   // Local pin outputs; pins two and three forced out with external oscillator.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         gout_r <= 4'h0;
         goe_r <= 4'h0;
      end else begin
         gout_r <= gpio_r[7:4];
         goe_r <= pwr_s ? dir_w : 4'h0;
      end
   end

   // APB slave: answers in the first access cycle, error on unmapped words.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
         ctrl_r <= `SVD_CTRL_RST;
         gpio_r <= `SVD_GPIO_RST;
         ssc_r <= `SVD_SSC_RST;
      end else begin
         pready_r <= setup_w;
         pslverr_r <= setup_w & ~hit_w;
         if (setup_w) begin
            prdata_r <= {24'h0, rd_w};
         end
         if (wr_w && h_ctrl) begin
            ctrl_r <= {3'b000, pwdata_in[4:0]};
         end
         if (wr_w && h_gpio) begin
            gpio_r <= pwdata_in[7:0];
         end
         if (wr_w && h_ssc) begin
            ssc_r <= {4'h0, pwdata_in[3:0]};
         end
      end
   end
endmodule // svd_des_end

// File: bench/svd_chk.sv
`timescale 1ns/1ps
// Watches the wire of link A and the back drivers of both lanes.
module svd_chk (
   input logic ref_clk_in,
   input logic reset_in,
   input logic s_clk,
   input logic s_dat,
   input logic s_frm,
   input logic b_oe,
   input logic b_oe_lane_b
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   clk_high_a:
      assert property ($rose(s_clk) |-> s_clk[*4] ##1 !s_clk) else $error("link clock high");
   clk_low_a:
      assert property ($fell(s_clk) |-> !s_clk[*4] ##1 s_clk) else $error("link clock low");
   dat_stable_a:
      assert property ($changed(s_dat) |-> !s_clk) else $error("forward bit moved");
   frame_period_a:
      assert property ($rose(s_frm) |-> ##224 $rose(s_frm)) else $error("frame spacing");
   frame_width_a:
      assert property ($rose(s_frm) |-> s_frm[*8] ##1 !s_frm) else $error("frame mark width");
   frame_edge_a:
      assert property ($rose(s_frm) |-> !s_clk) else $error("frame mark edge");
   frame_bit_a:
      assert property ($rose(s_frm) |-> ##[1:8] ($rose(s_clk) && s_frm)) else $error("frame bit");
   one_driver_a:
      assert property (!(b_oe && b_oe_lane_b)) else $error("both back drivers on");
   // Main scenarios: each lane's driver on, frames running.
   cover property ($rose(b_oe));
   cover property ($rose(b_oe_lane_b));
   cover property ($rose(s_frm));
endmodule // svd_chk

// File: bench/svd_tb.sv
`timescale 1ns/1ps
module testbench;
   import svd_pkg::*;
   logic clk = 1'h0, rst = 1'h1, pwr = 1'h1, psel = 1'h0, pen = 1'h0, pwt = 1'h0, inj = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pck, lock, pass, oen, err, prdy, cerr;
   logic [1:0] syn = 2'h0, sout;
   logic [11:0] pin = 12'h000, pout;
   logic [3:0] gin = 4'h0, gout, goe, gpo;
   svd_mode_t mode = SVD_MODE_12LF;
   int fail_count = 0, samples_checked = 0, i;
   int crc_errs = 0, c0;
   svd_link_if lnk_a ();
   svd_link_if lnk_b ();
   always #5 clk = ~clk;
   // Lane B has no camera, so its wires rest low.
   assign lnk_b.s_clk = 1'h0;
   assign lnk_b.s_dat = 1'h0;
   assign lnk_b.s_frm = 1'h0;
   // Each accepted pixel is followed by the next count value.
   always @(posedge clk) if (prdy) pin <= pin + 12'h001;
   // Back-channel check failures reported by the serializer end.
   always @(posedge clk) if (cerr === 1'h1) crc_errs++;
   svd_ser_end u_svd_ser_end (.ref_clk_in(clk), .reset_in(rst), .lnk(lnk_a), .mode_in(mode),
      .pix_data_in(pin), .line_frame_syncs_in(syn), .pix_valid_in(1'h1), .pix_ready_out(prdy),
      .par_err_inject_in(inj), .gpo_out(gpo), .back_crc_err_out(cerr));
   svd_des_end u_svd_des_end (.ref_clk_in(clk), .reset_in(rst), .lnk_a(lnk_a), .lnk_b(lnk_b),
      .mode_in(mode), .power_enable_pin_in(pwr), .input_select_pin_in(1'h0), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwt), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pix_data_out(pout),
      .line_frame_syncs_out(sout), .pix_clk_out(pck), .lock_out(lock), .pass_out(pass),
      .out_enable_out(oen), .gpio_in(gin), .gpio_out(gout), .gpio_oe_out(goe));
   svd_chk u_svd_chk (.ref_clk_in(clk), .reset_in(rst), .s_clk(lnk_a.s_clk),
      .s_dat(lnk_a.s_dat), .s_frm(lnk_a.s_frm), .b_oe(lnk_a.b_oe), .b_oe_lane_b(lnk_b.b_oe));
   task cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer; read data and error are taken at the pready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwt <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task wait_lock;
      for (i = 0; i < 3000 && lock !== 1'h1; i++) @(posedge clk);
      cmp(lock, 1);
   endtask
   task restart(input svd_mode_t m);
      rst <= 1'h1;
      mode <= m;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      repeat (800) @(posedge clk);
      cmp(lock, 0);
      wait_lock;
   endtask
   // Received pixels must follow the sent count with none lost.
   task pix_run(input logic [11:0] mask);
      logic [11:0] last;
      for (int k = 0; k < 8; k++) begin
         @(posedge pck);
         if (k > 0) cmp(pout & mask, (last + 12'h001) & mask);
         last = pout;
      end
   endtask
   task regs_run;
      apb(0, 8'h80, 0);
      cmp(rd, 32'h08);
      apb(1, 8'h08, 32'hFF);
      apb(0, 8'h08, 0);
      cmp(rd, 32'h0F);
      apb(0, 8'h04, 0);
      cmp(err, 1);
   endtask
   // A sync level changed once must reach the sync outputs.
   task sync_run;
      syn <= 2'h3;
      for (i = 0; i < 1000 && sout !== 2'h3; i++) @(posedge clk);
      cmp(sout, 2'h3);
   endtask
   // Injection is held one frame period, so exactly one frame start sees it.
   task parity_run;
      inj <= 1'h1;
      repeat (224) @(posedge clk);
      inj <= 1'h0;
      for (i = 0; i < 600 && pass !== 1'h0; i++) @(posedge clk);
      cmp(pass, 0);
      apb(1, 8'h68, 32'hFF);
      apb(0, 8'h68, 0);
      cmp(rd, 1);
      apb(0, 8'h6C, 0);
      cmp(rd, 0);
      for (i = 0; i < 600 && pass !== 1'h1; i++) @(posedge clk);
      cmp(pass, 1);
   endtask
   task power_run;
      pwr <= 1'h0;
      repeat (10) @(posedge clk);
      cmp({oen, lock, goe}, 0);
      pwr <= 1'h1;
      wait_lock;
      apb(0, 8'h68, 0);
      cmp(rd, 0);
   endtask
   task select_run;
      apb(1, 8'h80, 32'h0B);
      repeat (5) @(posedge clk);
      cmp({lnk_a.b_oe, lnk_b.b_oe, lock}, 3'h0);
      apb(1, 8'h80, 32'h0F);
      repeat (5) @(posedge clk);
      cmp({lnk_a.b_oe, lnk_b.b_oe, lock}, 3'h2);
      apb(0, 8'h88, 0);
      cmp(rd[2], 1);
      apb(1, 8'h80, 32'h08);
      apb(1, 8'h80, 32'h0C);
      wait_lock;
      cmp({lnk_a.b_oe, lnk_b.b_oe}, 2'h2);
   endtask
   // Forwarding must arrive within 2500 cycles, local pins at once.
   task gpio_run;
      c0 = crc_errs;
      gin <= 4'h5;
      for (i = 0; i < 2500 && gpo !== 4'h5; i++) @(posedge clk);
      cmp(gpo, 4'h5);
      apb(1, 8'h84, 32'hAF);
      repeat (3) @(posedge clk);
      cmp({goe, gout}, 8'hFA);
      apb(1, 8'h80, 32'h1C);
      apb(1, 8'h84, 32'hC0);
      repeat (3) @(posedge clk);
      cmp({goe, gout[3:2]}, 6'h33);
      cmp(crc_errs - c0, 0);
   endtask
   // Falling strobe: the pixel clock idles high and dips for one cycle per pixel.
   task edge_run;
      apb(1, 8'h80, 32'h04);
      repeat (3) @(posedge clk);
      for (i = 0; i < 500 && pck !== 1'h0; i++) @(posedge clk);
      cmp(pck, 0);
      @(posedge clk);
      cmp(pck, 1);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      restart(SVD_MODE_12LF);
      regs_run;
      pix_run(12'hFFF);
      restart(SVD_MODE_12HF);
      pix_run(12'hFFF);
      restart(SVD_MODE_10B);
      pix_run(12'h3FF);
      sync_run;
      parity_run;
      power_run;
      select_run;
      gpio_run;
      edge_run;
      test_done;
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #600000;
      fail_count++;
      test_done;
   end
endmodule // testbench
